// >>> hw/sweep_hop_sequencer.sv
// Overview of operation
// - Mode switches at once; output gated by switch
// - Sweep steps linearly from first end point
// - Bidirectional sweeps forward, then back
// - Hop alternates between the two end points
// - Step held for dwell, 26..65500 us
// - Span split into programmed equal points
// - Unselected parameters stay constant
// - AM depth accepted 0 to 100 percent
// - PM deviation accepted 0 to 180 degrees
// - Modulation off gives plain carrier
// - Internal trigger restarts sweep immediately
`include "sweep_hop_cfg.svh"

module sweep_hop_sequencer
  import sweep_hop_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output out_s             out_val,
  output logic             rf_on,
  output logic             mod_on,
  output logic      [1:0]  mod_kind,
  output logic      [7:0]  am_depth,
  output logic      [7:0]  pm_dev,
  output logic             step_pulse,
  output logic             sweep_flag
);

  function automatic logic [15:0] clamp16(input logic [31:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    if (v > 32'(hi)) begin
      return hi;
    end else if (v < 32'(lo)) begin
      return lo;
    end
    return v[15:0];
  endfunction

  // Point i of n+1 between a and b, rounded toward a; divider trades area for accuracy
  function automatic logic [31:0] lin_point(input logic [31:0] a,
                                            input logic [31:0] b,
                                            input logic [15:0] i,
                                            input logic [15:0] n);
    logic signed [32:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] quot;
    diff = $signed({1'b0, b}) - $signed({1'b0, a});
    prod = diff * $signed({1'b0, i});
    quot = prod / $signed({34'h0, n});
    return a + quot[31:0];
  endfunction

  // Register group
  ctrl_s       ctrl_q, ctrl_d;
  logic [15:0] dwell_q, dwell_d;
  logic [15:0] pts_q, pts_d;
  logic [31:0] fa_q, fa_d, fb_q, fb_d;
  logic [31:0] la_q, la_d, lb_q, lb_d;
  logic [31:0] pa_q, pa_d, pb_q, pb_d;
  logic [15:0] am_q, am_d, pm_q, pm_d;
  logic [31:0] rdata_q, rdata_d;

  // Sequencer group
  seq_state_e  state_q, state_d;
  logic [15:0] idx_q, idx_d;
  logic        dir_q, dir_d;
  logic        run, restart, step;
  logic [15:0] last;

  // Output group
  out_s        out_q, out_d;
  logic        rf_q, rf_d, modon_q, modon_d, flag_q, flag_d;

  always_comb begin
    ctrl_d  = ctrl_q;
    dwell_d = dwell_q;
    pts_d   = pts_q;
    fa_d    = fa_q;
    fb_d    = fb_q;
    la_d    = la_q;
    lb_d    = lb_q;
    pa_d    = pa_q;
    pb_d    = pb_q;
    am_d    = am_q;
    pm_d    = pm_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL:     ctrl_d  = ctrl_s'(reg_wdata[`CTRL_W-1:0]);
        `REG_DWELL:    dwell_d = clamp16(reg_wdata, `DWELL_MIN_US,
                                         `DWELL_MAX_US);
        `REG_POINTS:   pts_d   = clamp16(reg_wdata, `POINTS_MIN,
                                         `POINTS_MAX);
        `REG_FREQ_A:   fa_d    = reg_wdata;
        `REG_FREQ_B:   fb_d    = reg_wdata;
        `REG_LEVEL_A:  la_d    = reg_wdata;
        `REG_LEVEL_B:  lb_d    = reg_wdata;
        `REG_PHASE_A:  pa_d    = reg_wdata;
        `REG_PHASE_B:  pb_d    = reg_wdata;
        `REG_AM_DEPTH: am_d    = clamp16(reg_wdata, 16'h0000, `AM_MAX_PCT);
        `REG_PM_DEV:   pm_d    = clamp16(reg_wdata, 16'h0000, `PM_MAX_DEG);
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL:     rdata_d = 32'(ctrl_q);
        `REG_DWELL:    rdata_d = 32'(dwell_q);
        `REG_POINTS:   rdata_d = 32'(pts_q);
        `REG_FREQ_A:   rdata_d = fa_q;
        `REG_FREQ_B:   rdata_d = fb_q;
        `REG_LEVEL_A:  rdata_d = la_q;
        `REG_LEVEL_B:  rdata_d = lb_q;
        `REG_PHASE_A:  rdata_d = pa_q;
        `REG_PHASE_B:  rdata_d = pb_q;
        `REG_AM_DEPTH: rdata_d = 32'(am_q);
        `REG_PM_DEV:   rdata_d = 32'(pm_q);
        `REG_STATUS: begin
          rdata_d[15:0]           = idx_q;
          rdata_d[`STAT_DIR_BIT]  = dir_q;
          rdata_d[`STAT_RUN_BIT]  = (state_q == S_RUN);
          rdata_d[`STAT_FLAG_BIT] = flag_q;
        end
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q  <= ctrl_s'(`CTRL_RST);
      dwell_q <= `DWELL_MIN_US;
      pts_q   <= `POINTS_MIN;
      fa_q    <= 32'h0000_0000;
      fb_q    <= 32'h0000_0000;
      la_q    <= 32'h0000_0000;
      lb_q    <= 32'h0000_0000;
      pa_q    <= 32'h0000_0000;
      pb_q    <= 32'h0000_0000;
      am_q    <= 16'h0000;
      pm_q    <= 16'h0000;
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q  <= ctrl_d;
      dwell_q <= dwell_d;
      pts_q   <= pts_d;
      fa_q    <= fa_d;
      fb_q    <= fb_d;
      la_q    <= la_d;
      lb_q    <= lb_d;
      pa_q    <= pa_d;
      pb_q    <= pb_d;
      am_q    <= am_d;
      pm_q    <= pm_d;
      rdata_q <= rdata_d;
    end
  end

  // Any settings write restarts the plan so stale points never show
  assign run     = (ctrl_q.gen == GEN_SWEEP);
  assign restart = reg_wr || !run || (state_q == S_IDLE);
  assign last    = pts_q - 16'h0001;

  step_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .restart    (restart),
    .dwell_us   (dwell_q),
    .step_pulse (step)
  );

  always_comb begin
    state_d = state_q;
    idx_d   = idx_q;
    dir_d   = dir_q;
    case (state_q)
      S_IDLE: begin
        idx_d = 16'h0000;
        dir_d = 1'b0;
        if (run && !reg_wr) begin
          state_d = S_RUN;
        end
      end
      S_RUN: begin
        if (!run || reg_wr) begin
          state_d = S_IDLE;
          idx_d   = 16'h0000;
          dir_d   = 1'b0;
        end else if (step) begin
          case (ctrl_q.swp_mode)
            SWP_LINEAR: idx_d = (idx_q >= last) ? 16'h0000
                                                : idx_q + 16'h0001;
            SWP_BIDIR: begin
              if (!dir_q) begin
                if (idx_q >= last) begin
                  dir_d = 1'b1;
                  idx_d = idx_q - 16'h0001;
                end else begin
                  idx_d = idx_q + 16'h0001;
                end
              end else if (idx_q == 16'h0000) begin
                dir_d = 1'b0;
                idx_d = 16'h0001;
              end else begin
                idx_d = idx_q - 16'h0001;
              end
            end
            SWP_HOP: idx_d = (idx_q == 16'h0000) ? last : 16'h0000;
            default: idx_d = 16'h0000;
          endcase
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      idx_q   <= 16'h0000;
      dir_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q   <= idx_d;
      dir_q   <= dir_d;
    end
  end

  always_comb begin
    out_d = '{freq: fa_q, level: la_q, phase: pa_q};
    // equal spacing, others held at first end point
    if (run) begin
      if (ctrl_q.sweep_type[0]) out_d.freq  = lin_point(fa_q, fb_q,
                                                         idx_q, last);
      if (ctrl_q.sweep_type[1]) out_d.level = lin_point(la_q, lb_q,
                                                         idx_q, last);
      if (ctrl_q.sweep_type[2]) out_d.phase = lin_point(pa_q, pb_q,
                                                         idx_q, last);
    end
    case (ctrl_q.gen)
      GEN_CW:    rf_d = ctrl_q.out_cw;
      GEN_SWEEP: rf_d = ctrl_q.out_swp;
      GEN_ARB:   rf_d = ctrl_q.out_arb;
      default:   rf_d = 1'b0;
    endcase
    modon_d = rf_d && ctrl_q.mod_en && (ctrl_q.mod_type != 2'b11);
    // Low on the closing point of each sweep
    case (ctrl_q.swp_mode)
      SWP_BIDIR: flag_d = !(dir_q && idx_q == 16'h0000);
      default:   flag_d = (idx_q != last);
    endcase
    flag_d = flag_d && (state_q == S_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_q   <= '0;
      rf_q    <= 1'b0;
      modon_q <= 1'b0;
      flag_q  <= 1'b0;
    end else begin
      out_q   <= out_d;
      rf_q    <= rf_d;
      modon_q <= modon_d;
      flag_q  <= flag_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign out_val    = out_q;
  assign rf_on      = rf_q;
  assign mod_on     = modon_q;
  assign mod_kind   = ctrl_q.mod_type;
  assign am_depth   = am_q[7:0];
  assign pm_dev     = pm_q[7:0];
  assign step_pulse = step;
  assign sweep_flag = flag_q;

  a_output_gate: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (ctrl_q.gen == GEN_SWEEP && !ctrl_q.out_swp) |=> !rf_on)
    else $error("output on while switch off");

  a_mode_restart: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_wr && reg_addr == `REG_CTRL) |=> ##1 idx_q == 16'h0000)
    else $error("mode write did not restart sequence");

  a_linear_step: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (step && !reg_wr && run && ctrl_q.swp_mode == SWP_LINEAR
     && idx_q < last) |=> idx_q == $past(idx_q) + 16'h0001)
    else $error("linear sweep did not advance by one");

  a_sweep_wrap: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (step && !reg_wr && run && ctrl_q.swp_mode == SWP_LINEAR
     && idx_q == last) |=> idx_q == 16'h0000)
    else $error("sweep did not restart at end");

  a_bidir_turn: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (step && !reg_wr && run && ctrl_q.swp_mode == SWP_BIDIR && !dir_q
     && idx_q == last) |=> dir_q && idx_q == $past(last) - 16'h0001)
    else $error("bidirectional sweep did not turn");

  a_hop_ends: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (ctrl_q.swp_mode == SWP_HOP && $stable(pts_q))
    |-> (idx_q == 16'h0000 || idx_q == last))
    else $error("hop left the end points");

  a_dwell_range: assert property (
    @(posedge core_clk) disable iff (!resetn)
    dwell_q >= `DWELL_MIN_US && dwell_q <= `DWELL_MAX_US)
    else $error("dwell out of range");

  a_hold_fixed: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (!ctrl_q.sweep_type[0]) |=> out_val.freq == $past(fa_q))
    else $error("unselected frequency moved");

  a_am_bound: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_wr && reg_addr == `REG_AM_DEPTH && reg_wdata > 32'h64)
    |=> am_depth == 8'h64)
    else $error("am depth not limited to full scale");

  a_pm_bound: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (reg_wr && reg_addr == `REG_PM_DEV && reg_wdata > 32'hb4)
    |=> pm_dev == 8'hb4)
    else $error("pm deviation not limited to full scale");

  a_mod_off: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !ctrl_q.mod_en |=> !mod_on)
    else $error("modulation active while switched off");

endmodule // sweep_hop_sequencer

// >>> hw/sweep_hop_cfg.svh
`ifndef SWEEP_HOP_CFG_SVH
`define SWEEP_HOP_CFG_SVH

// Register byte offsets
`define REG_CTRL      8'h00
`define REG_DWELL     8'h04
`define REG_POINTS    8'h08
`define REG_FREQ_A    8'h0c
`define REG_FREQ_B    8'h10
`define REG_LEVEL_A   8'h14
`define REG_LEVEL_B   8'h18
`define REG_PHASE_A   8'h1c
`define REG_PHASE_B   8'h20
`define REG_AM_DEPTH  8'h24
`define REG_PM_DEV    8'h28
`define REG_STATUS    8'h2c

// Control word layout, low bits of the write data
`define CTRL_W        13
`define CTRL_RST      13'h0000

// Status word layout
`define STAT_DIR_BIT  16
`define STAT_RUN_BIT  17
`define STAT_FLAG_BIT 18

// Reset values and bounds
`define DWELL_MIN_US  16'h001a
`define DWELL_MAX_US  16'hffdc
`define POINTS_MIN    16'h0002
`define POINTS_MAX    16'hffff
`define AM_MAX_PCT    16'h0064
`define PM_MAX_DEG    16'h00b4

// Timing: 1 us tick from a 5 ns clock
`define TICK_NS       1000
`define CLK_PERIOD_NS 5
`define TICK_CYCLES   (`TICK_NS / `CLK_PERIOD_NS)

`endif

// >>> hw/sweep_hop_pkg.sv
package sweep_hop_pkg;

  typedef enum logic [1:0] {GEN_CW, GEN_SWEEP, GEN_ARB} gen_mode_e;
  typedef enum logic [1:0] {SWP_LINEAR, SWP_BIDIR, SWP_HOP} sweep_mode_e;
  typedef enum logic [1:0] {MOD_AM, MOD_FM, MOD_PM} mod_type_e;
  typedef enum logic {S_IDLE, S_RUN} seq_state_e;

  // Bit 0 frequency, bit 1 level, bit 2 phase
  typedef struct packed {
    logic [2:0] sweep_type;
    logic [1:0] mod_type;
    logic       mod_en;
    logic [1:0] swp_mode;
    logic       out_arb;
    logic       out_swp;
    logic       out_cw;
    logic [1:0] gen;
  } ctrl_s;

  typedef struct packed {
    logic [31:0] freq;
    logic [31:0] level;
    logic [31:0] phase;
  } out_s;

endpackage

// >>> hw/step_timer.sv
`include "sweep_hop_cfg.svh"

module step_timer #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        restart,
  input  wire logic [15:0] dwell_us,
  output logic             step_pulse
);

  logic [15:0] div_q, div_d;
  logic [15:0] cnt_q, cnt_d;
  logic        tick;

  always_comb begin
    div_d      = div_q;
    cnt_d      = cnt_q;
    tick       = (div_q == 16'(TICK_CYCLES - 1));
    step_pulse = 1'b0;
    if (restart) begin
      div_d = 16'h0000;
      cnt_d = dwell_us;
    end else begin
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
      if (tick) begin
        if (cnt_q == 16'h0001) begin
          step_pulse = 1'b1;
          cnt_d      = dwell_us;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      div_q <= 16'h0000;
      cnt_q <= `DWELL_MIN_US;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
    end
  end

  // Helper: cycles since last step or restart
  logic [31:0] gap_q;
  always_ff @(posedge core_clk) begin
    if (!resetn || restart || step_pulse) begin
      gap_q <= 32'h0000_0000;
    end else begin
      gap_q <= gap_q + 32'h0000_0001;
    end
  end

  a_dwell_gap: assert property (
    @(posedge core_clk) disable iff (!resetn)
    step_pulse |-> gap_q == 32'(dwell_us) * 32'(TICK_CYCLES) - 32'h1)
    else $error("step spacing differs from dwell");

  a_tick_reload: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (step_pulse && !restart) |=> cnt_q == $past(dwell_us))
    else $error("dwell counter not reloaded at step");

endmodule // step_timer

// >>> tb/host_master.sv
module host_master (
  input  wire logic        core_clk,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released lines show the inverse so stale values never match by luck
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
endmodule // host_master

// >>> tb/sweep_hop_sequencer_test.sv
`include "sweep_hop_cfg.svh"

module sweep_hop_sequencer_test;
  import sweep_hop_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Short tick keeps a 26 us dwell at 52 cycles
  localparam int TICKS     = 2;
  localparam int DWELL_CYC = 26 * TICKS;

  logic        core_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  out_s        out_val;
  logic        rf_on;
  logic        mod_on;
  logic [1:0]  mod_kind;
  logic [7:0]  am_depth;
  logic [7:0]  pm_dev;
  logic        step_pulse;
  logic        sweep_flag;
  int          error_cnt;
  int          samples_checked;
  logic [31:0] rdv;

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  sweep_hop_sequencer #(.TICK_CYCLES(TICKS)) u_sweep_hop_sequencer (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .out_val, .rf_on, .mod_on, .mod_kind, .am_depth,
    .pm_dev, .step_pulse, .sweep_flag);

  host_master u_host_master (
    .core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Returns the number of cycles since the call, stopping at the pulse
  task automatic wait_step(output int cyc);
    cyc = 0;
    while (cyc < 4000) begin
      @(negedge core_clk);
      cyc++;
      if (step_pulse === 1'b1) return;
    end
    error_cnt++;
    conclude();
  endtask

  // Four points between the end points
  function automatic int pt(input int a, input int b, input int i);
    return a + ((b - a) * i) / 3;
  endfunction

  function automatic int idx_of(input int mode, input int k);
    int bd[9] = '{0, 1, 2, 3, 2, 1, 0, 1, 2};
    if (mode == 0) return k % 4;
    if (mode == 2) return (k % 2) * 3;
    return bd[k];
  endfunction

  task automatic run_plan(input logic [31:0] ctrl, input logic [8:0] last);
    int          cyc;
    int          i;
    logic [31:0] ef;
    logic [31:0] el;
    logic [31:0] ep;
    u_host_master.wr(`REG_CTRL, ctrl);
    wait_step(cyc);
    for (int k = 0; k < 9; k++) begin
      i  = idx_of(int'(ctrl[6:5]), k);
      ef = ctrl[10] ? pt(100, 400, i) : 100;
      el = ctrl[11] ? pt(7, 99, i) : 7;
      ep = ctrl[12] ? pt(3, 303, i) : 3;
      check("freq", out_val.freq, ef);
      check("level", out_val.level, el);
      check("phase", out_val.phase, ep);
      check("flag", 32'(sweep_flag), 32'(!last[k]));
      check("rf_on", 32'(rf_on), 32'd1);
      wait_step(cyc);
      check("dwell", cyc, DWELL_CYC);
    end
  endtask

  // Last two: sweep with its switch off, and modulation code three
  logic [15:0] cw_ctrl[9] = '{16'h0004, 16'h0008, 16'h0012, 16'h0284,
                              16'h0204, 16'h0084, 16'h0184, 16'h0395,
                              16'h0384};
  logic [3:0]  cw_exp[9]  = '{4'h8, 4'h0, 4'h8, 4'he, 4'ha, 4'hc, 4'hd,
                              4'h3, 4'hb};
  int          amv[3]     = '{0, 100, 200};
  int          pmv[3]     = '{0, 180, 500};

  initial begin
    resetn = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    @(negedge core_clk);
    check("reset outs", 32'({|out_val, rf_on, mod_on, sweep_flag,
          step_pulse, am_depth, pm_dev}), 32'h0);
    @(posedge core_clk);
    resetn <= 1'b1;
    u_host_master.rd(`REG_DWELL, rdv);
    check("dwell rst", rdv, 32'd26);
    u_host_master.rd(`REG_POINTS, rdv);
    check("points rst", rdv, 32'd2);
    u_host_master.wr(`REG_DWELL, 32'h0000_0005);
    u_host_master.rd(`REG_DWELL, rdv);
    check("dwell low", rdv, 32'd26);
    u_host_master.wr(`REG_DWELL, 32'h0000_ffff);
    u_host_master.rd(`REG_DWELL, rdv);
    check("dwell high", rdv, 32'd65500);
    u_host_master.wr(`REG_DWELL, 32'd26);
    // Unmapped place must not disturb the dwell
    u_host_master.wr(8'h30, 32'h0000_ffff);
    u_host_master.rd(8'h30, rdv);
    check("unmapped", rdv, 32'h0);
    u_host_master.rd(`REG_DWELL, rdv);
    check("dwell kept", rdv, 32'd26);
    for (int k = 0; k < 3; k++) begin
      u_host_master.wr(`REG_AM_DEPTH, 32'(amv[k]));
      u_host_master.wr(`REG_PM_DEV, 32'(pmv[k]));
      repeat (2) @(negedge core_clk);
      check("am", 32'(am_depth), 32'(amv[k] > 100 ? 100 : amv[k]));
      check("pm", 32'(pm_dev), 32'(pmv[k] > 180 ? 180 : pmv[k]));
    end
    u_host_master.wr(`REG_POINTS, 32'd4);
    u_host_master.wr(`REG_FREQ_A, 32'd100);
    u_host_master.wr(`REG_FREQ_B, 32'd400);
    u_host_master.wr(`REG_LEVEL_A, 32'd7);
    u_host_master.wr(`REG_LEVEL_B, 32'd99);
    u_host_master.wr(`REG_PHASE_A, 32'd3);
    u_host_master.wr(`REG_PHASE_B, 32'd303);
    // The second and third plans cut into the previous one mid-sweep
    run_plan(32'h0000_0409, 9'h088);
    run_plan(32'h0000_1429, 9'h040);
    run_plan(32'h0000_0849, 9'h0aa);
    for (int k = 0; k < 9; k++) begin
      u_host_master.wr(`REG_CTRL, 32'(cw_ctrl[k]));
      repeat (2) @(negedge core_clk);
      check("mode outs", 32'({rf_on, mod_on, mod_kind}),
            32'(cw_exp[k]));
      check("cw level", out_val.level, 32'd7);
    end
    conclude();
  end
endmodule // sweep_hop_sequencer_test
